// ### mcu_model.sv
/* Controller side of the link: step pin, direction and chip select.
   Assumes one clock; the bench calls pulse() for each step. */
`timescale 1ns/1ps
module mcu_model (
  input  wire logic core_clk,
  output logic      step_o,
  output logic      dir_o,
  output logic      cs_n_o
);
  // Select idles high so flags and fault pin can update
  initial begin
    step_o = 1'b0;
    dir_o  = 1'b0;
    cs_n_o = 1'b1;
  end
  // High level held 4 clocks and low level 6, longer than the step synchroniser needs
  task automatic pulse();
    @(posedge core_clk);
    step_o <= 1'b1;
    repeat (4) @(posedge core_clk);
    step_o <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : pulse
  // Direction changes one edge ahead of the next step
  task automatic set_dir(input logic d);
    @(posedge core_clk);
    dir_o <= d;
  endtask : set_dir
endmodule : mcu_model

// ### stepper_diag_watchdog_ctrl.sv
/*
  Step synchronisation, peak current, back-EMF control, fault latching,
  reset output and windowed watchdog of a bipolar stepper driver.
  Assumes analog detectors and pins arrive asynchronously and that
  software reaches the registers over Avalon-MM with waitrequest.
*/
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
// Contract
// - new step mode applied on next step pulse
// - finer mode snaps position to nearest grid
// - coarser change on shared position keeps zero offset
// - coarser change off grid keeps phase offset
// - peak current change applied next regulation period
// - back-EMF sampled at every coil zero crossing
// - transparent select tracks, else holds end sample
// - gain select picks divide by two or four
// - over warning temperature sets thermal warning flag
// - shutdown temperature sets flag, drivers high impedance
// - shutdown flag clears only when cool and read
// - overcurrent latches per transistor, drivers off until cleared
// - full duty beyond limit sets coil open flag
// - pump fault reads one while pump low
// - any fault flag pulls fault output low
// - power-up holds reset output low for a while
// - enabled watchdog rewritten before timeout restarts timer
// - early or late refresh pulses reset output
// - watchdog reset sets boot-type flag
// - four-bit field selects watchdog timeout
// - held hard reset clears registers, reset output untouched
// - step edge per polarity moves translator up/down
// - status read clears flags; updates only with select high (boot-type flag here sets regardless of select)
`timescale 1ns/1ps
module stepper_diag_watchdog_ctrl
  import stepper_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              step_pulse_input,
  input  wire logic              step_dir,
  input  wire logic              serial_cs_n,
  input  wire logic              hard_reset_input,
  input  wire logic              temp_warn_det,
  input  wire logic              temp_shutdown_det,
  input  wire logic [3:0]        ovc_a_det,
  input  wire logic [3:0]        ovc_b_det,
  input  wire logic              pump_low_det,
  input  wire logic              duty_full_a,
  input  wire logic              duty_full_b,
  input  wire logic              pwm_period_start,
  input  wire logic              izero_a,
  input  wire logic              izero_b,
  output logic      [6:0]        translator_pos,
  output logic      [4:0]        peak_current_setting,
  output logic                   bemf_transparent_select,
  output logic                   bemf_gain_select,
  output logic                   bemf_sample,
  output logic                   drivers_hiz,
  output logic                   fault_n_o,
  output logic                   fault_n_oe,
  output logic                   reset_out_n_o,
  output logic                   reset_out_n_oe
);

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Input synchronisation and edge detection
  // ----------------------------------------------------------------------
  async_in_s raw, in_s, prev_q;
  step_cfg_s step_cfg_q;

  assign raw = '{step: step_pulse_input, dir: step_dir, cs_n: serial_cs_n,
                 hrst: hard_reset_input, temp_warn: temp_warn_det,
                 temp_sd: temp_shutdown_det, ovc_a: ovc_a_det, ovc_b: ovc_b_det,
                 pump_low: pump_low_det, duty_full: {duty_full_b, duty_full_a},
                 period: pwm_period_start, izero: {izero_b, izero_a}};

  sync2 #(.W($bits(async_in_s))) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        (raw),
    .q        (in_s)
  );

  always_ff @(posedge core_clk) begin
    if (srst) prev_q <= '0;
    else      prev_q <= in_s;
  end

  logic step_ev, period_ev, cs_high;
  assign step_ev   = (in_s.step ^ prev_q.step)
                     & (prev_q.step == step_cfg_q.pol);
  assign period_ev = in_s.period & ~prev_q.period;
  assign cs_high   = in_s.cs_n;

  // ----------------------------------------------------------------------
  // Hard reset qualification
  // ----------------------------------------------------------------------
  logic [HRST_W-1:0] hcnt_q;
  logic              clr_int, int_rst;

  // Short glitches on the pin do not reach the registers
  always_ff @(posedge core_clk) begin
    if (srst || !in_s.hrst)               hcnt_q <= '0;
    else if (hcnt_q != HRST_W'(HRST_MIN_CYC)) hcnt_q <= hcnt_q + HRST_W'(1);
  end
  assign clr_int = (hcnt_q == HRST_W'(HRST_MIN_CYC));
  assign int_rst = srst | clr_int;

  // ----------------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick;

  assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (srst || tick) tick_cnt_q <= '0;
    else              tick_cnt_q <= tick_cnt_q + TICK_W'(1);
  end

  // ----------------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ----------------------------------------------------------------------
  wd_cfg_s      wd_cfg_q;
  logic [4:0]   cur_q;
  fault_flags_s flags_q, status_view;
  step_mode_e   act_mode_q;
  logic [4:0]   cur_act_q;
  logic [6:0]   pos_q;
  logic         ack_q, acc_rd, acc_wr, rd_status, wd_write;
  logic [31:0]  rd_word, readdata_q;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign acc_rd    = avs_read & ack_q;
  assign acc_wr    = avs_write & ack_q & avs_byteenable[0];
  assign rd_status = acc_rd & (avs_address == OFS_STATUS);
  assign wd_write  = acc_wr & (avs_address == OFS_WATCHDOG);

  always_ff @(posedge core_clk) begin
    if (srst) ack_q <= 1'b0;
    else      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_word = '0;
    unique case (avs_address)
      OFS_STEP_CFG: rd_word = 32'(step_cfg_q);
      OFS_CURRENT:  rd_word = 32'(cur_q);
      OFS_WATCHDOG: rd_word = 32'(wd_cfg_q);
      OFS_STATUS:   rd_word = 32'(status_view);
      OFS_POSITION: rd_word = {11'h000, cur_act_q, 5'h00, act_mode_q, 1'b0, pos_q};
      default:      rd_word = '0;
    endcase
  end

  // Data captured in the wait cycle stands at the completing edge
  always_ff @(posedge core_clk) begin
    if (srst)                       readdata_q <= '0;
    else if (avs_read && !ack_q)    readdata_q <= rd_word;
  end
  assign avs_readdata = readdata_q;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic wd_fire;

  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      step_cfg_q <= STEP_CFG_RST;
      cur_q      <= CUR_RST;
    end else if (acc_wr) begin
      if (avs_address == OFS_STEP_CFG)
        step_cfg_q <= step_cfg_s'(avs_writedata[$bits(step_cfg_s)-1:0]);
      if (avs_address == OFS_CURRENT)  cur_q <= avs_writedata[4:0];
    end
  end

  // A watchdog reset disarms the watchdog so the restarted controller
  // is not caught again before it can re-arm it
  always_ff @(posedge core_clk) begin
    if (int_rst || wd_fire) wd_cfg_q <= WD_CFG_RST;
    else if (wd_write)      wd_cfg_q <= wd_cfg_s'(avs_writedata[$bits(wd_cfg_s)-1:0]);
  end

  // ----------------------------------------------------------------------
  // Translator and step mode synchronisation
  // ----------------------------------------------------------------------
  function automatic logic [6:0] mode_inc(input step_mode_e m);
    return (m > MODE_FULL) ? (7'h01 << MODE_FULL) : (7'h01 << m);
  endfunction : mode_inc

  logic [6:0] inc_new, inc_old, mask_new, base, pos_d;
  logic       finer;

  assign inc_new  = mode_inc(step_cfg_q.mode);
  assign inc_old  = mode_inc(act_mode_q);
  assign mask_new = inc_new - 7'h01;
  assign finer    = inc_new < inc_old;

  // Finer grid: round to the nearest finer position before stepping.
  // Coarser grid: step from where we are, so an offset survives.
  always_comb begin
    base = pos_q;
    if (finer) base = (pos_q + (inc_new >> 1)) & ~mask_new;
    pos_d = in_s.dir ? base - inc_new : base + inc_new;
  end

  // The programmed mode waits for the next step edge
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      act_mode_q <= STEP_CFG_RST.mode;
      pos_q      <= '0;
    end else if (step_ev) begin
      act_mode_q <= step_cfg_q.mode;
      pos_q      <= pos_d;
    end
  end
  assign translator_pos = pos_q;

  // ----------------------------------------------------------------------
  // Peak current and back-EMF control
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (int_rst)        cur_act_q <= CUR_RST;
    else if (period_ev) cur_act_q <= cur_q;
  end
  assign peak_current_setting = cur_act_q;

  // Sample strobe at the end of each zero crossing on either coil
  always_ff @(posedge core_clk) begin
    if (int_rst) bemf_sample <= 1'b0;
    else         bemf_sample <= |(prev_q.izero & ~in_s.izero);
  end
  assign bemf_transparent_select = step_cfg_q.transp;
  assign bemf_gain_select        = step_cfg_q.gain;

  // ----------------------------------------------------------------------
  // Open coil timers
  // ----------------------------------------------------------------------
  logic [OPEN_W-1:0] open_cnt_q [2];
  logic [1:0]        open_set;

  for (genvar i = 0; i < 2; i++) begin : g_open
    // Coil keeps being driven; this only observes the duty cycle
    always_ff @(posedge core_clk) begin
      if (int_rst || !in_s.duty_full[i])
        open_cnt_q[i] <= '0;
      else if (tick && open_cnt_q[i] != OPEN_W'(OPEN_COIL_MS))
        open_cnt_q[i] <= open_cnt_q[i] + OPEN_W'(1);
    end
    assign open_set[i] = (open_cnt_q[i] == OPEN_W'(OPEN_COIL_MS));
  end

  // ----------------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------------
  fault_flags_s set_v, clr_v;

  // Sets wait for chip select high, except the boot flag so a reset
  // cause is never lost; a set always beats a clear in the same cycle
  always_comb begin
    set_v         = '0;
    set_v.tw      = in_s.temp_warn;
    set_v.thermal_shutdown_flag     = in_s.temp_sd;
    set_v.ovc_a   = in_s.ovc_a & {4{~drivers_hiz}};
    set_v.ovc_b   = in_s.ovc_b & {4{~drivers_hiz}};
    set_v.open_a  = open_set[0];
    set_v.open_b  = open_set[1];
    set_v.pump    = in_s.pump_low;
    if (!cs_high) set_v = '0;
    set_v.wd_boot = wd_fire;
    clr_v         = rd_status ? '1 : '0;
    clr_v.thermal_shutdown_flag     = rd_status & ~in_s.temp_warn;
  end

  always_ff @(posedge core_clk) begin
    if (int_rst) flags_q <= '0;
    else         flags_q <= (flags_q & ~clr_v) | set_v;
  end

  always_comb begin
    status_view      = flags_q;
    status_view.pump = flags_q.pump | in_s.pump_low;
  end

  // Drivers open while shutdown or any overcurrent is latched
  always_ff @(posedge core_clk) begin
    if (int_rst) drivers_hiz <= 1'b0;
    else drivers_hiz <= flags_q.thermal_shutdown_flag | (|flags_q.ovc_a) | (|flags_q.ovc_b);
  end

  // Fault pin follows the flags only while chip select is high
  logic fault_q;
  always_ff @(posedge core_clk) begin
    if (int_rst)      fault_q <= 1'b0;
    else if (cs_high) fault_q <= |status_view;
  end
  assign fault_n_o  = 1'b0;
  assign fault_n_oe = fault_q;

  // ----------------------------------------------------------------------
  // Windowed watchdog
  // ----------------------------------------------------------------------
  logic [MS_W-1:0] wd_cnt_q, wd_limit;
  logic            refresh;

  assign wd_limit = MS_W'(({1'b0, wd_cfg_q.interval} + 5'h01) * WD_BASE_MS);
  assign refresh  = wd_write & avs_writedata[0] & wd_cfg_q.en;
  assign wd_fire  = wd_cfg_q.en & ~clr_int &
                    ((refresh & (wd_cnt_q < MS_W'(WD_EARLY_MS))) |
                     (wd_cnt_q == wd_limit));

  always_ff @(posedge core_clk) begin
    if (int_rst || !wd_cfg_q.en || refresh || wd_fire) wd_cnt_q <= '0;
    else if (tick)                                     wd_cnt_q <= wd_cnt_q + MS_W'(1);
  end

  // ----------------------------------------------------------------------
  // Reset output: power-up hold and watchdog pulse
  // ----------------------------------------------------------------------
  logic [MS_W-1:0] por_cnt_q;
  logic            rst_hold_q;

  // Hard reset is kept out of here so it never drives the pin
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_hold_q <= 1'b1;
      por_cnt_q  <= '0;
    end else if (wd_fire) begin
      rst_hold_q <= 1'b1;
      por_cnt_q  <= '0;
    end else if (rst_hold_q && tick) begin
      if (por_cnt_q == MS_W'(POR_HOLD_MS - 1)) rst_hold_q <= 1'b0;
      por_cnt_q <= por_cnt_q + MS_W'(1);
    end
  end
  assign reset_out_n_o  = 1'b0;
  assign reset_out_n_oe = rst_hold_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_early_refresh;
    !clr_int && refresh && wd_cnt_q < MS_W'(WD_EARLY_MS);
  endsequence

  sequence s_reset_pulse;
    reset_out_n_oe && flags_q.wd_boot ##1 reset_out_n_oe;
  endsequence

  chk_mode_on_step: assert property (
    !clr_int && $changed(act_mode_q) |-> $past(step_ev || clr_int))
    else $error("step mode changed without a step edge");

  chk_finer_snap: assert property (
    step_ev && finer && !clr_int |=> (pos_q & $past(mask_new)) == 7'h00)
    else $error("finer mode left position off grid");

  chk_coarse_step: assert property (
    step_ev && !finer && !in_s.dir && !clr_int |=> pos_q == $past(pos_q) + $past(inc_new))
    else $error("coarse step did not keep position offset");

  chk_cur_period: assert property (
    !clr_int && $changed(cur_act_q) |-> $past(period_ev || clr_int))
    else $error("peak current changed outside a period start");

  chk_bemf_sample: assert property (
    !clr_int && prev_q.izero[0] && !in_s.izero[0] |=> bemf_sample)
    else $error("zero crossing end missed a sample strobe");

  chk_tsd_drivers: assert property (
    !clr_int && cs_high && in_s.temp_sd ##1 !clr_int |=> drivers_hiz)
    else $error("shutdown did not open the drivers");

  chk_tsd_hold: assert property (
    !clr_int && flags_q.thermal_shutdown_flag && in_s.temp_warn |=> flags_q.thermal_shutdown_flag)
    else $error("shutdown flag cleared while still warm");

  chk_pump_reads: assert property (
    in_s.pump_low |-> status_view.pump)
    else $error("pump fault not reported while pump low");

  chk_fault_pin: assert property (
    cs_high && (|status_view) && !clr_int |=> fault_n_oe)
    else $error("fault pin not pulled with a flag set");

  chk_wd_early: assert property (
    s_early_refresh |=> s_reset_pulse)
    else $error("early refresh did not pulse reset");

  chk_wd_timeout: assert property (
    wd_cfg_q.en && !clr_int && wd_cnt_q == wd_limit |=> reset_out_n_oe && !wd_cfg_q.en)
    else $error("watchdog timeout did not pulse reset");

  chk_hard_reset: assert property (
    clr_int && !reset_out_n_oe |=> !reset_out_n_oe && pos_q == 7'h00 && !wd_cfg_q.en)
    else $error("hard reset misbehaved");

  chk_por_hold: assert property (
    $fell(srst) |-> reset_out_n_oe)
    else $error("reset output not held after power-up");

  chk_status_clear: assert property (
    rd_status && !set_v.tw && !clr_int |=> !flags_q.tw)
    else $error("status read did not clear warning flag");

endmodule : stepper_diag_watchdog_ctrl

// ### stepper_diag_watchdog_ctrl_tb_top.sv
/* Bench: register bus, step modes, faults, watchdog and hard reset.
   Assumes TICK_CYCLES of 8, so one millisecond is 8 clocks. */
`timescale 1ns/1ps
module stepper_diag_watchdog_ctrl_tb_top
  import stepper_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = '0, avs_readdata, got;
  logic [3:0] avs_byteenable = 4'hF, ovc_a_det = 4'h0, ovc_b_det = 4'h0;
  logic hard_reset_input = 1'b0, temp_warn_det = 1'b0, temp_shutdown_det = 1'b0;
  logic pump_low_det = 1'b0, duty_full_a = 1'b0, duty_full_b = 1'b0;
  logic pwm_period_start = 1'b0, izero_a = 1'b0, izero_b = 1'b0;
  logic step_pulse_input, step_dir, serial_cs_n, bemf_sample, drivers_hiz;
  logic [6:0] translator_pos;
  logic [4:0] peak_current_setting;
  logic bemf_transparent_select, bemf_gain_select;
  logic fault_n_o, fault_n_oe, reset_out_n_o, reset_out_n_oe;
  logic [31:0] cfg [5] = '{32'h05, 32'h00, 32'h04, 32'h0B, 32'h0A};
  logic [31:0] ex [5] = '{32'h20, 32'h21, 32'h31, 32'h38, 32'h3C};
  int mismatches = 0;
  int checks = 0;
  mcu_model i_mcu_model (.core_clk, .step_o(step_pulse_input), .dir_o(step_dir),
    .cs_n_o(serial_cs_n));
  stepper_diag_watchdog_ctrl #(.TICK_CYCLES(8)) i_stepper_diag_watchdog_ctrl (
    .core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .step_pulse_input, .step_dir,
    .serial_cs_n, .hard_reset_input, .temp_warn_det, .temp_shutdown_det, .ovc_a_det,
    .ovc_b_det, .pump_low_det, .duty_full_a, .duty_full_b, .pwm_period_start,
    .izero_a, .izero_b, .translator_pos, .peak_current_setting,
    .bemf_transparent_select, .bemf_gain_select, .bemf_sample, .drivers_hiz,
    .fault_n_o, .fault_n_oe, .reset_out_n_o, .reset_out_n_oe);
  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, g, e);
    end
  endtask : chk
  // Request held until waitrequest is seen low; bounded so a hang counts
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    got = avs_readdata;
    if (n >= 20) mismatches++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask : rd_chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(12);
    srst <= 1'b0;
    tick(2);
    chk(reset_out_n_oe, 1);
    tick(40);
    chk(reset_out_n_oe, 0);
    rd_chk(OFS_STEP_CFG, 32'h0);
    rd_chk(5'h14, 32'h0);
    // Mode changes wait for a step; finer snaps, coarser keeps offset
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_STEP_CFG, cfg[i]);
      tick(4);
      chk({25'h0, translator_pos}, i == 0 ? 32'h0 : ex[i - 1]);
      i_mcu_model.pulse();
      chk({25'h0, translator_pos}, ex[i]);
    end
    bus(1'b1, OFS_STEP_CFG, 32'h3A);
    tick(1);
    chk({bemf_gain_select, bemf_transparent_select}, 32'h3);
    i_mcu_model.set_dir(1'b1);
    i_mcu_model.pulse();
    chk({25'h0, translator_pos}, 32'h38);
    i_mcu_model.set_dir(1'b0);
    bus(1'b1, OFS_CURRENT, 32'h15);
    tick(4);
    chk(peak_current_setting, 32'h0);
    pwm_period_start <= 1'b1;
    tick(4);
    pwm_period_start <= 1'b0;
    tick(2);
    chk(peak_current_setting, 32'h15);
    rd_chk(OFS_POSITION, 32'h00150238);
    temp_warn_det <= 1'b1;
    tick(6);
    chk(fault_n_oe, 1);
    temp_warn_det <= 1'b0;
    tick(4);
    rd_chk(OFS_STATUS, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    tick(4);
    chk(fault_n_oe, 0);
    ovc_a_det <= 4'h2;
    tick(6);
    chk(drivers_hiz, 1);
    ovc_a_det <= 4'h0;
    tick(4);
    rd_chk(OFS_STATUS, 32'h8);
    tick(2);
    chk(drivers_hiz, 0);
    pump_low_det <= 1'b1;
    tick(6);
    rd_chk(OFS_STATUS, 32'h1000);
    pump_low_det <= 1'b0;
    tick(6);
    rd_chk(OFS_STATUS, 32'h1000);
    // Shutdown stays latched while warm, then clears on a cool read
    temp_shutdown_det <= 1'b1;
    temp_warn_det <= 1'b1;
    tick(6);
    chk(drivers_hiz, 1);
    temp_shutdown_det <= 1'b0;
    tick(4);
    rd_chk(OFS_STATUS, 32'h3);
    rd_chk(OFS_STATUS, 32'h3);
    temp_warn_det <= 1'b0;
    tick(6);
    rd_chk(OFS_STATUS, 32'h3);
    rd_chk(OFS_STATUS, 32'h0);
    // Full duty for 32 ms flags an open coil
    duty_full_a <= 1'b1;
    tick(240);
    chk(fault_n_oe, 0);
    tick(40);
    chk(fault_n_oe, 1);
    duty_full_a <= 1'b0;
    tick(6);
    rd_chk(OFS_STATUS, 32'h400);
    // One sample strobe at the end of a zero crossing
    izero_a <= 1'b1;
    tick(4);
    izero_a <= 1'b0;
    tick(4);
    chk(bemf_sample, 1);
    tick(1);
    chk(bemf_sample, 0);
    // Interval 1 times out after 512 clocks, not 256
    bus(1'b1, OFS_WATCHDOG, 32'h3);
    tick(400);
    chk(reset_out_n_oe, 0);
    for (int k = 0; k < 150 && reset_out_n_oe !== 1'b1; k++) @(posedge core_clk);
    chk(reset_out_n_oe, 1);
    tick(40);
    rd_chk(OFS_STATUS, 32'h2000);
    bus(1'b1, OFS_WATCHDOG, 32'h1);
    tick(20);
    bus(1'b1, OFS_WATCHDOG, 32'h1);
    tick(4);
    chk(reset_out_n_oe, 1);
    tick(40);
    hard_reset_input <= 1'b1;
    tick(40);
    hard_reset_input <= 1'b0;
    tick(6);
    chk(reset_out_n_oe, 0);
    rd_chk(OFS_CURRENT, 32'h0);
    chk({25'h0, translator_pos}, 32'h0);
    chk({fault_n_o, reset_out_n_o}, 32'h0);
    stop_test();
  end
  // Whole run is about 1250 clocks
  initial begin
    tick(5000);
    mismatches++;
    stop_test();
  end
endmodule : stepper_diag_watchdog_ctrl_tb_top

// ### stepper_pkg.sv
/*
  Shared constants, field layouts and types of the stepper supervision block.
  Assumes one 250 MHz system clock and a 32-bit Avalon-MM register port.
*/
package stepper_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned TICK_NS          = 1000000;  // Millisecond time base
  localparam int unsigned TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned OPEN_COIL_MS     = 32;
  localparam int unsigned POR_HOLD_MS      = 4;
  localparam int unsigned WD_BASE_MS       = 32;       // Timeout step per interval code
  localparam int unsigned WD_EARLY_MS      = 16;       // Watchdog early limit
  localparam int unsigned HRST_MIN_NS      = 100;      // Hard reset least pulse
  localparam int unsigned HRST_MIN_CYC     = (HRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_W             = 10;
  localparam int unsigned OPEN_W           = 6;
  localparam int unsigned HRST_W           = 6;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned  ADDR_W       = 5;
  localparam logic [4:0]   OFS_STEP_CFG = 5'h00;
  localparam logic [4:0]   OFS_CURRENT  = 5'h04;
  localparam logic [4:0]   OFS_WATCHDOG = 5'h08;
  localparam logic [4:0]   OFS_STATUS   = 5'h0C;
  localparam logic [4:0]   OFS_POSITION = 5'h10;
  localparam logic [4:0]   CUR_RST      = 5'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_1_32, MODE_1_16, MODE_1_8, MODE_1_4, MODE_HALF, MODE_FULL
  } step_mode_e;

  typedef struct packed {
    logic       gain;         // bemf_gain_select: 1 divides by four
    logic       transp;       // bemf_transparent_select
    logic       pol;          // step_edge_polarity: 1 steps on falling edge
    step_mode_e mode;
  } step_cfg_s;

  typedef struct packed {
    logic [3:0] interval;     // watchdog_interval_select
    logic       en;           // watchdog_enable
  } wd_cfg_s;

  typedef struct packed {
    logic       wd_boot;
    logic       pump;
    logic       open_b;
    logic       open_a;
    logic [3:0] ovc_b;
    logic [3:0] ovc_a;
    logic       thermal_shutdown_flag;
    logic       tw;
  } fault_flags_s;

  typedef struct packed {
    logic       step;
    logic       dir;
    logic       cs_n;
    logic       hrst;
    logic       temp_warn;
    logic       temp_sd;
    logic [3:0] ovc_a;
    logic [3:0] ovc_b;
    logic       pump_low;
    logic [1:0] duty_full;
    logic       period;
    logic [1:0] izero;
  } async_in_s;

  localparam step_cfg_s STEP_CFG_RST = '0;
  localparam wd_cfg_s   WD_CFG_RST   = '0;

endpackage : stepper_pkg

// ### sync2.sv
/*
  Two flip-flop synchroniser for a vector of unrelated level inputs.
  Assumes each bit is sampled independently; no bus coherence is implied.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sync2
